// ### verilog/adc_clock_and_sequence_ctrl.sv
// digital control of a successive-approximation converter: clock
// derivation and the sync, sample, convert, write-result sequence
// assumes the comparator output arrives asynchronously from the analog
// stage and that the divider code comes from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module adc_clock_and_sequence_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter logic [3:0] SYNC_TICKS = `SYNC_TICKS,
	parameter logic [3:0] SAMPLE_TICKS = `SAMPLE_TICKS,
	parameter logic [3:0] WRITE_TICKS = `WRITE_TICKS
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire divsel_t analog_clock_divider_select,
	input wire logic convStart,
	input wire logic [`CHAN_W-1:0] channelSel,
	input wire logic compIn,
	output logic analogInputClkEn,
	output logic analogInternalClk,
	output logic digitalPartClkEn,
	output logic sampleHold,
	output logic [`CHAN_W-1:0] activeChannel,
	output logic [`RESULT_W-1:0] dacCode,
	output logic [`RESULT_W-1:0] result,
	output logic resultValid,
	output logic busy,
	output logic [2:0] phaseCode
);

	phase_t phase;
	phase_t next_phase;
	divsel_t ratioSel;
	divsel_t next_ratioSel;
	logic [3:0] phaseCnt;
	logic [3:0] next_phaseCnt;
	logic [`RESULT_W-1:0] sar;
	logic [`RESULT_W-1:0] next_sar;
	logic [`RESULT_W-1:0] trial;
	logic [`RESULT_W-1:0] next_trial;
	logic [`RESULT_W-1:0] next_result;
	logic [`CHAN_W-1:0] next_activeChannel;
	logic next_resultValid;
	logic compMeta;
	logic compSync;
	logic tick;

	// comparator crosses from the analog stage: two flops, nothing else
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			compMeta <= 1'b0;
			compSync <= 1'b0;
		end else begin
			compMeta <= compIn;
			compSync <= compMeta;
		end
	end

	// one counter makes the analog input tick and internal clock level
	adc_clock_prescaler u_prescaler (
		.ref_clk(ref_clk),
		.srst(srst),
		.ratioSel(ratioSel),
		.tick(tick),
		.clkLevel(analogInternalClk)
	);

	// digital part runs at the module rate, so its enable is high whenever srst is low
	assign digitalPartClkEn = ~srst;
	assign analogInputClkEn = tick;

	// sequence next-state; idle leaves on convStart, later phases advance only on internal analog ticks
	always_comb begin
		next_phase = phase;
		next_ratioSel = ratioSel;
		next_phaseCnt = phaseCnt;
		next_sar = sar;
		next_trial = trial;
		next_result = result;
		next_activeChannel = activeChannel;
		next_resultValid = 1'b0;
		case (phase)
			PH_IDLE: begin
				// divider code is taken only here, never mid-conversion
				next_ratioSel = analog_clock_divider_select;
				if (convStart) begin
					next_phase = PH_SYNC;
					next_phaseCnt = '0;
					next_activeChannel = channelSel;
				end
			end
			PH_SYNC: begin
				if (tick) begin
					if (phaseCnt == SYNC_TICKS - 4'h1) begin
						next_phase = PH_SAMPLE;
						next_phaseCnt = '0;
					end else begin
						next_phaseCnt = phaseCnt + 4'h1;
					end
				end
			end
			PH_SAMPLE: begin
				if (tick) begin
					if (phaseCnt == SAMPLE_TICKS - 4'h1) begin
						next_phase = PH_CONVERT;
						next_phaseCnt = '0;
						next_sar = '0;
						next_trial = {1'b1, {(`RESULT_W-1){1'b0}}};
					end else begin
						next_phaseCnt = phaseCnt + 4'h1;
					end
				end
			end
			PH_CONVERT: begin
				// keep the trial bit when the input is at or above the code
				if (tick) begin
					if (compSync) begin
						next_sar = sar | trial;
					end
					next_trial = trial >> 1;
					if (trial[0]) begin
						next_phase = PH_WRITE;
						next_phaseCnt = '0;
					end
				end
			end
			PH_WRITE: begin
				if (tick) begin
					if (phaseCnt == WRITE_TICKS - 4'h1) begin
						next_result = sar;
						next_resultValid = 1'b1;
						next_phase = PH_IDLE;
						next_phaseCnt = '0;
					end else begin
						next_phaseCnt = phaseCnt + 4'h1;
					end
				end
			end
			default: begin
				next_phase = PH_IDLE;
				next_phaseCnt = '0;
			end
		endcase
	end

	// sequence registers; divider code resets to divide-by-32
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase <= PH_IDLE;
			ratioSel <= `DIVSEL_RESET;
			phaseCnt <= '0;
			sar <= '0;
			trial <= '0;
			result <= '0;
			activeChannel <= '0;
			resultValid <= 1'b0;
		end else begin
			phase <= next_phase;
			ratioSel <= next_ratioSel;
			phaseCnt <= next_phaseCnt;
			sar <= next_sar;
			trial <= next_trial;
			result <= next_result;
			activeChannel <= next_activeChannel;
			resultValid <= next_resultValid;
		end
	end

	// trial code to the capacitor array; the comparator has a whole
	// analog period minus two sync cycles to settle, so ratio 2 leaves it no time at all
	assign dacCode = sar | trial;
	assign sampleHold = (phase == PH_SAMPLE);
	assign busy = (phase != PH_IDLE);
	assign phaseCode = phase;

endmodule : adc_clock_and_sequence_ctrl

`default_nettype wire

// ### verilog/adc_ctrl_cfg.svh
// constants for the converter clock and sequence control
// assumes inclusion by bare name from the package and design modules
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// divider-select codes and the ratios they give
`define DIVSEL_W 2
`define DIVSEL_DIV2 2'h0
`define DIVSEL_DIV3 2'h1
`define DIVSEL_DIV4 2'h2
`define DIVSEL_DIV32 2'h3
`define DIVSEL_RESET 2'h3
`define RATIO_DIV2 6'h02
`define RATIO_DIV3 6'h03
`define RATIO_DIV4 6'h04
`define RATIO_DIV32 6'h20
`define RATIO_W 6

// result and channel widths
`define RESULT_W 10
`define CHAN_W 3

// phase lengths in internal analog clock periods
`define SYNC_TICKS 4'h1
`define SAMPLE_TICKS 4'h2
`define WRITE_TICKS 4'h1

// module clock and analog clock ceiling, in MHz
`define MODULE_CLK_MHZ 100
`define ANALOG_CLK_MAX_MHZ 10

`endif

// ### verilog/adc_ctrl_pkg.sv
// types and shared decode for the converter clock and sequence control
// assumes adc_ctrl_cfg.svh on the include path
`include "adc_ctrl_cfg.svh"

package adc_ctrl_pkg;

	// conversion phases, binary coded
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_SYNC = 3'h1,
		PH_SAMPLE = 3'h2,
		PH_CONVERT = 3'h3,
		PH_WRITE = 3'h4
	} phase_t;

	typedef logic [`DIVSEL_W-1:0] divsel_t;
	typedef logic [`RATIO_W-1:0] ratio_t;

	// divider-select code to division ratio
	function automatic ratio_t ratio_of(input divsel_t sel);
		case (sel)
			`DIVSEL_DIV2: ratio_of = `RATIO_DIV2;
			`DIVSEL_DIV3: ratio_of = `RATIO_DIV3;
			`DIVSEL_DIV4: ratio_of = `RATIO_DIV4;
			default: ratio_of = `RATIO_DIV32;
		endcase
	endfunction : ratio_of

endpackage : adc_ctrl_pkg

// ### verilog/adc_clock_prescaler.sv
// prescaler: module clock to analog input clock tick and analog clock level
// assumes a single module clock and a ratio held stable by the caller
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module adc_clock_prescaler
	import adc_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire divsel_t ratioSel,
	output logic tick,
	output logic clkLevel
);

	ratio_t cnt;
	ratio_t next_cnt;
	ratio_t ratio;
	logic next_clkLevel;

	// wrap on >= so a ratio change never strands the counter above its end
	always_comb begin
		ratio = ratio_of(ratioSel);
		if (cnt >= ratio - `RATIO_W'(1)) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + `RATIO_W'(1);
		end
		// high for the first half of each period; odd ratios lean low
		next_clkLevel = (next_cnt < (ratio >> 1));
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt <= '0;
			clkLevel <= 1'b0;
		end else begin
			cnt <= next_cnt;
			clkLevel <= next_clkLevel;
		end
	end

	assign tick = (cnt >= ratio - `RATIO_W'(1));

endmodule : adc_clock_prescaler

`default_nettype wire

// ### dv/adc_ctrl_checker_sva.sv
// checker for the converter control ports
// assumes one module clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic convStart,
	input wire logic analogInputClkEn,
	input wire logic [2:0] activeChannel,
	input wire logic [9:0] dacCode,
	input wire logic resultValid,
	input wire logic busy,
	input wire logic sampleHold,
	input wire logic [2:0] phaseCode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// a phase that has just ended
	sequence s_left(logic [2:0] p);
		phaseCode == p ##1 phaseCode != p;
	endsequence
	chk_start_sync:
		assert property (convStart && !busy |=> phaseCode == 3'h1)
		else $error("no sync after start");
	chk_sync_sample:
		assert property (s_left(3'h1) |-> phaseCode == 3'h2)
		else $error("sync not followed by sample");
	chk_sample_convert:
		assert property (s_left(3'h2) |-> phaseCode == 3'h3 && dacCode == 10'h200)
		else $error("bad convert entry");
	chk_convert_write:
		assert property (s_left(3'h3) |-> phaseCode == 3'h4)
		else $error("convert not followed by write");
	chk_write_result:
		assert property (s_left(3'h4) |-> phaseCode == 3'h0 && resultValid)
		else $error("write ended without result");
	chk_valid_single:
		assert property (resultValid |=> !resultValid)
		else $error("result strobe too long");
	chk_channel_hold:
		assert property (busy ##1 busy |-> $stable(activeChannel))
		else $error("channel moved while busy");
	chk_sample_level:
		assert property (sampleHold == (phaseCode == 3'h2))
		else $error("sample hold outside sample phase");
	chk_tick_pulse:
		assert property (analogInputClkEn |=> !analogInputClkEn)
		else $error("tick wider than one cycle");
endmodule : adc_ctrl_checker
bind adc_clock_and_sequence_ctrl adc_ctrl_checker u_chk (.ref_clk, .srst,
	.convStart, .analogInputClkEn, .activeChannel, .dacCode, .resultValid,
	.busy, .sampleHold, .phaseCode);
`default_nettype wire

// ### dv/analog_stage_model.sv
// analog stage: comparator of held level against the trial code
// assumes the bench holds the level through a conversion
`timescale 1ns/1ps
`default_nettype none
module analog_stage_model (
	input wire logic ref_clk,
	input wire logic [9:0] dacCode,
	input wire logic [9:0] level,
	output logic compIn
);
	// one cycle of settling, as a real comparator lags the code
	always_ff @(posedge ref_clk) begin
		compIn <= level >= dacCode;
	end
endmodule : analog_stage_model
`default_nettype wire

// ### dv/adc_clock_and_sequence_ctrl_test.sv
// bench for the converter clock and sequence control
// assumes the analog stage model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module adc_clock_and_sequence_ctrl_test;
	import adc_ctrl_pkg::*;
	// analog ticks per conversion: sync, sample, one per bit, write
	localparam int NTICKS = `SYNC_TICKS + `SAMPLE_TICKS + `RESULT_W
		+ `WRITE_TICKS;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic convStart = 1'b0;
	divsel_t divSel = `DIVSEL_RESET;
	logic [2:0] channelSel = 3'h0, activeChannel, phaseCode;
	logic [9:0] level = 10'h000, dacCode, result;
	logic compIn, inClkEn, intClk, digClkEn, resultValid, busy;
	int err_count = 0, num_checks = 0;
	int rt[4] = '{2, 3, 4, 32};
	logic [12:0] expQ[$];
	adc_clock_and_sequence_ctrl DUT (.ref_clk, .srst,
		.analog_clock_divider_select(divSel), .convStart, .channelSel,
		.compIn, .analogInputClkEn(inClkEn), .analogInternalClk(intClk),
		.digitalPartClkEn(digClkEn), .sampleHold(), .activeChannel,
		.dacCode, .result, .resultValid, .busy, .phaseCode);
	analog_stage_model partner (.ref_clk, .dacCode, .level, .compIn);
	always #5 ref_clk = ~ref_clk;
	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask : step
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// three periods; the first two let a new ratio settle
	task automatic measure(input divsel_t code, input int ratio);
		int n, h;
		divSel = code;
		repeat (3) begin
			n = 0;
			h = 0;
			do begin
				step();
				n++;
				h += int'(intClk === 1'b1);
			end while (inClkEn !== 1'b1 && n < 99);
		end
		check(13'(n), 13'(ratio));
		check(13'(h), 13'(ratio / 2));
		$display("code %0d done", code);
	endtask : measure
	// divider and channel are disturbed while busy and must not matter
	task automatic convert(input logic [2:0] ch, input logic [9:0] lvl);
		int n;
		channelSel = ch;
		level = lvl;
		convStart = 1'b1;
		expQ.push_back({ch, lvl});
		step();
		convStart = 1'b0;
		divSel = `DIVSEL_DIV2;
		channelSel = ~ch;
		for (n = 0; n < 999 && resultValid !== 1'b1; n++)
			step();
		// back to a legal ratio before idle can pick the code up
		divSel = `DIVSEL_DIV32;
		// first tick lands 1..32 cycles after start; a hang fails too
		check(13'(n > (NTICKS - 1) * rt[3] && n <= NTICKS * rt[3]), 13'h1);
		$display("level %h done", lvl);
	endtask : convert
	// results are matched oldest first
	always @(posedge ref_clk) begin
		#1;
		if (resultValid === 1'b1)
			check({activeChannel, result}, expQ.pop_front());
	end
	initial begin
		void'($urandom(88742));
		repeat (4) step();
		srst = 1'b0;
		step();
		check(13'({digClkEn, busy}), 13'h2);
		for (int i = 3; i >= 0; i--)
			measure(divsel_t'(i), rt[i]);
		divSel = `DIVSEL_DIV32;
		convert(3'h0, 10'h000);
		convert(3'h7, 10'h3ff);
		repeat (4) convert(3'($urandom), 10'($urandom));
		step();
		summarize();
	end
	// hang guard, well past the expected run
	initial begin
		#200000;
		err_count++;
		summarize();
	end
endmodule : adc_clock_and_sequence_ctrl_test
`default_nettype wire
